// ---- bench/led_blink_sequencer_tb.sv ----
// testbench: register access over the serial port, then blink timing at led_drive
// assumes: design with TICK_CLKS_P = 1, sda pull-up modelled here
`timescale 1ns/1ps
`default_nettype none
module led_blink_sequencer_tb;
	import blink_pkg::*;
	logic       ref_clk;
	logic       reset_n;
	logic       scl_m;
	logic       sda_m;
	logic       sda_in;
	logic       sda_out;
	logic       sda_oe;
	logic       addr_sel;
	logic [2:0] led_drive;
	logic [6:0] dev_addr;
	logic [7:0] rd;
	logic       ack;
	int         cyc;
	int         t0;
	int         last_rise;
	int         num_errors;
	int         total_checks;
	localparam int HALF [16] = '{0, 2, 5, 10, 15, 20, 30, 40, 60, 80, 100, 120, 140, 160,
		180, 200};
	localparam logic [7:0] RA [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0B,
		8'h11, 8'h12, 8'h20};
	localparam logic [7:0] RX [10] = '{8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'h03,
		8'h08, 8'h07, 8'h00};
	localparam int TS [9] = '{1550, 2550, 5050, 10550, 11550, 26050, 30550, 49050, 55050};

	led_blink_sequencer #(.TICK_CLKS_P(1)) u_dut (
		.ref_clk  (ref_clk),
		.reset_n  (reset_n),
		.scl_in   (scl_m),
		.sda_in   (sda_in),
		.sda_out  (sda_out),
		.sda_oe   (sda_oe),
		.addr_sel (addr_sel),
		.led_drive(led_drive)
	);

	assign sda_in = sda_oe ? sda_out : sda_m;

	initial begin
		ref_clk = 1'b0;
	end
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;

	task automatic hc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic tally_and_finish();
		if (num_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_led(input string what, input logic [2:0] exp);
		total_checks++;
		if (led_drive !== exp) begin
			num_errors++;
			$display("Error %s expected %b seen %b", what, exp, led_drive);
		end
	endtask

	task automatic i2c_bit(input logic b, output logic got);
		sda_m = b;
		hc(6);
		scl_m = 1'b1;
		last_rise = cyc;
		hc(6);
		got = sda_in;
		scl_m = 1'b0;
		hc(6);
	endtask

	task automatic i2c_start();
		sda_m = 1'b1;
		hc(6);
		scl_m = 1'b1;
		hc(6);
		sda_m = 1'b0;
		hc(6);
		scl_m = 1'b0;
		hc(6);
	endtask

	task automatic i2c_stop();
		sda_m = 1'b0;
		hc(6);
		scl_m = 1'b1;
		hc(6);
		sda_m = 1'b1;
		hc(6);
	endtask

	task automatic wr_byte(input logic [7:0] b, input logic exp_ack);
		logic g;
		for (int i = 7; i >= 0; i--) i2c_bit(b[i], g);
		i2c_bit(1'b1, g);
		chk_byte("ack", {7'h00, exp_ack}, {7'h00, g});
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		i2c_start();
		wr_byte({dev_addr, 1'b0}, 1'b0);
		wr_byte(a, 1'b0);
		wr_byte(d, 1'b0);
		i2c_stop();
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
		logic g;
		i2c_start();
		wr_byte({dev_addr, 1'b0}, 1'b0);
		wr_byte(a, 1'b0);
		i2c_start();
		wr_byte({dev_addr, 1'b1}, 1'b0);
		for (int i = 7; i >= 0; i--) i2c_bit(1'b1, v[i]);
		i2c_bit(1'b1, g);
		i2c_stop();
	endtask

	task automatic do_reset();
		reset_n = 1'b0;
		hc(12);
		reset_n = 1'b1;
		hc(6);
	endtask

	function automatic logic exp_at(input int t, input int ms, input logic [7:0] tim);
		int ph;
		int off;
		int stop;
		ph = (t / ms) % 200;
		off = HALF[tim[3:0]];
		stop = off + HALF[tim[7:4]];
		if (stop > 200) stop = 200;
		return (ph >= off) && (ph < stop);
	endfunction

	initial begin
		repeat (95000) @(posedge ref_clk);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		cyc = 0;
		num_errors = 0;
		total_checks = 0;
		scl_m = 1'b1;
		sda_m = 1'b1;
		addr_sel = 1'b0;
		dev_addr = 7'h54;
		reset_n = 1'b0;
		do_reset();
		for (int i = 0; i < 10; i++) reg_wr(RA[i], 8'hFF);
		for (int i = 0; i < 10; i++) begin
			reg_rd(RA[i], rd);
			chk_byte("masked readback", RX[i], rd);
		end
		do_reset();
		chk_led("led after reset", 3'b000);
		for (int i = 0; i < 10; i++) begin
			reg_rd(RA[i], rd);
			chk_byte("reset value", 8'h00, rd);
		end
		reg_wr(8'h12, 8'h05);
		chk_led("switch only", 3'b101);
		reg_wr(8'h02, 8'h08);
		chk_led("group not blink", 3'b101);
		reg_wr(8'h0B, 8'h01);
		chk_led("enabled unstarted", 3'b100);
		addr_sel = 1'b1;
		hc(6);
		i2c_start();
		wr_byte({7'h54, 1'b0}, 1'b1);
		i2c_stop();
		dev_addr = 7'h55;
		reg_wr(8'h01, 8'h3A);
		reg_wr(8'h03, 8'h11);
		reg_wr(8'h04, 8'h0A);
		reg_wr(8'h05, 8'hEA);
		reg_wr(8'h06, 8'h09);
		reg_wr(8'h12, 8'h07);
		reg_wr(8'h11, 8'h08);
		t0 = last_rise;
		for (int i = 0; i < 9; i++) begin
			hc(t0 + TS[i] - cyc);
			chk_led("blink phase", {exp_at(TS[i], 250, 8'hEA), exp_at(TS[i], 500, 8'h11),
				exp_at(TS[i], 100, 8'h3A)});
		end
		reg_wr(8'h11, 8'h00);
		chk_led("start cleared", 3'b000);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ---- design/blink_channel.sv ----
// one blink channel: off period, on period, dark remainder, repeating
// assumes: tick every 1/200 ms, restart is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module blink_channel (
	input  wire logic                ref_clk,
	input  wire logic                reset_n,
	input  wire logic                tick,
	input  wire logic                restart,
	input  wire logic                blink,
	input  wire logic                run,
	input  wire blink_pkg::chan_cfg_t cfg,
	output logic                     led
);
	import blink_pkg::*;

	chan_state_t q;
	chan_state_t d;
	logic [8:0]  off_h;
	logic [8:0]  on_end;
	logic [8:0]  lim;
	logic [12:0] last_step;
	logic        in_on;

	// percentage codes to half-percent steps
	assign off_h = {1'b0, PCT_HALF[cfg.off]}; // [RULE7]
	assign on_end = off_h + {1'b0, PCT_HALF[cfg.on]}; // [RULE7]
	// on time is cut so off plus on never passes the cycle
	assign lim = (on_end > {1'b0, STEPS}) ? {1'b0, STEPS} : on_end; // [RULE10]
	assign last_step = CYCLE_MS[cfg.cyc] - 13'h0001; // [RULE8]
	assign in_on = ({1'b0, q.phase} >= off_h) && ({1'b0, q.phase} < lim); // [RULE9] [RULE11]

	always_comb begin
		d = q;
		if (restart || !run || !blink) begin
			d.step = '0; // [RULE3]
			d.phase = '0;
		end else if (tick) begin
			if (q.step >= last_step) begin
				d.step = '0;
				d.phase = (q.phase >= STEPS - 8'h01) ? 8'h00 : q.phase + 8'h01; // [RULE14]
			end else begin
				d.step = q.step + 13'h0001;
			end
		end
		d.led = cfg.sw & (blink ? (run & in_on) : 1'b1); // [RULE2] [RULE5]
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= CHAN_RESET;
		end else begin
			q <= d;
		end
	end

	assign led = q.led;

	a_off_dark: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE9]
		(blink && run && {1'b0, q.phase} < off_h) |=> !led)
		else $error("led lit during off period");
	a_on_cut: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE10]
		(blink && {1'b0, q.phase} >= lim) |=> !led)
		else $error("led lit after on window");
	a_on_lit: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE9]
		(blink && run && cfg.sw && in_on) |=> led)
		else $error("led dark inside on window");
	a_restart_align: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE3]
		restart |=> (q.phase == 8'h00 && q.step == 13'h0000))
		else $error("restart did not clear counters");
	a_switch_only: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE5]
		!blink |=> (led == $past(cfg.sw)))
		else $error("led does not follow switch");
	a_phase_wrap: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE14]
		(blink && run && !restart && tick && q.step >= last_step
		&& q.phase == STEPS - 8'h01) |=> (q.phase == 8'h00))
		else $error("phase did not wrap");
	c_led_on: cover property (@(posedge ref_clk) disable iff (!reset_n)
		blink && run && $rose(led));
	c_wrap: cover property (@(posedge ref_clk) disable iff (!reset_n)
		blink && run && q.phase == STEPS - 8'h01 ##1 q.phase == 8'h00);
endmodule
`default_nettype wire

// ---- design/led_blink_sequencer.sv ----
// top of the led blink sequencer: serial register port, registers, channels
// assumes: scl and sda arrive from pins; sda is open drain, driven low only
// Functional notes
// RULE1: blinking runs only while the output group select field holds 01b.
// RULE2: bit 3 of each cycle register enables blinking for that channel.
// RULE3: writing the start bit high starts all enabled channels together.
// RULE4: software sets timing and enables before raising the start bit.
// RULE5: one switch bit per channel turns that output on or off.
// RULE6: timing register holds on code in bits 7-4, off code in 3-0.
// RULE7: 4-bit codes map to 0,1,2.5,5,7.5,10..90,100 percent of cycle.
// RULE8: cycle code in bits 2-0 selects 0.1 s up to 5 s.
// RULE9: each cycle is off period, then on period, then dark remainder.
// RULE10: when off plus on exceeds 100 percent, on time is cut.
// RULE11: when off plus on is under 100 percent, remainder stays dark.
// RULE12: start bit sits at bit 3 of the sequencer control register.
// RULE13: a written byte takes effect on scl rise of the final ack.
// RULE14: a tick counter times the cycle, repeating while enabled and started.
`timescale 1ns/1ps
`default_nettype none
module led_blink_sequencer #(
	parameter int TICK_CLKS_P = blink_pkg::TICK_CLKS
) (
	input  wire logic           ref_clk,
	input  wire logic           reset_n,
	input  wire logic           scl_in,
	input  wire logic           sda_in,
	output logic                sda_out,
	output logic                sda_oe,
	input  wire logic           addr_sel,
	output logic [2:0]          led_drive
);
	import blink_pkg::*;

	if (TICK_CLKS_P < 1 || TICK_CLKS_P > 65535) begin : g_bad_tick
		$error("tick divider out of range");
	end

	localparam logic [15:0] PRE_LAST = 16'(TICK_CLKS_P - 1);

	top_state_t  q;
	top_state_t  d;
	bus_pins_t   pins_raw;
	bus_pins_t   pin;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;
	logic        tick;
	logic        group_ok;
	logic [6:0]  dev_addr;
	logic [7:0]  rd_val;

	assign pins_raw = '{addr_sel: addr_sel, sda: sda_in, scl: scl_in};

	pin_sync u_sync (
		.ref_clk  (ref_clk),
		.reset_n  (reset_n),
		.pins_in  (pins_raw),
		.pins_out (pin)
	);

	assign scl_rise = pin.scl & ~q.scl_prev;
	assign scl_fall = ~pin.scl & q.scl_prev;
	assign start_c = pin.scl & q.scl_prev & q.sda_prev & ~pin.sda;
	assign stop_c = pin.scl & q.scl_prev & ~q.sda_prev & pin.sda;
	assign dev_addr = {DEV_ADDR_BASE[6:1], pin.addr_sel};
	assign tick = (q.pre == PRE_LAST); // [RULE14]
	assign group_ok = (q.group == GROUP_BLINK); // [RULE1]

	// register read mux; unmapped offsets read zero
	always_comb begin
		rd_val = 8'h00;
		for (int i = 0; i < NCH; i++) begin
			if (q.ptr == ch_reg(i, 1'b0)) begin
				rd_val = q.timing[i];
			end
			if (q.ptr == ch_reg(i, 1'b1)) begin
				rd_val = {4'h0, q.cyc[i]};
			end
		end
		if (q.ptr == REG_GROUP_CFG) begin
			rd_val = {6'h00, q.group};
		end
		if (q.ptr == REG_SEQ_CTRL) begin
			rd_val = 8'(q.start) << START_BIT;
		end
		if (q.ptr == REG_SWITCH) begin
			rd_val = {5'h00, q.sw};
		end
	end

	always_comb begin
		d = q;
		d.scl_prev = pin.scl;
		d.sda_prev = pin.sda;
		d.restart = 1'b0;
		d.pre = (q.restart || tick) ? 16'h0000 : q.pre + 16'h0001; // [RULE3] [RULE14]
		if (start_c) begin
			d.st = ST_ADDR;
			d.cnt = 4'h0;
			d.oe = 1'b0;
		end else if (stop_c) begin
			d.st = ST_IDLE;
			d.cnt = 4'h0;
			d.oe = 1'b0;
		end else if (q.st != ST_IDLE && scl_rise) begin
			if (q.cnt < ACK_CNT) begin
				d.cnt = q.cnt + 4'h1;
				if (q.st != ST_RDATA) begin
					d.sh = {q.sh[6:0], pin.sda};
				end
			end else if (q.cnt == ACK_CLK_CNT && q.st == ST_WDATA) begin
				// byte lands on the rising scl edge of its ack
				for (int i = 0; i < NCH; i++) begin
					if (q.ptr == ch_reg(i, 1'b0)) begin
						d.timing[i] = q.sh; // [RULE6] [RULE13]
					end
					if (q.ptr == ch_reg(i, 1'b1)) begin
						d.cyc[i] = q.sh[3:0]; // [RULE2] [RULE8] [RULE13]
					end
				end
				if (q.ptr == REG_GROUP_CFG) begin
					d.group = q.sh[GROUP_LSB +: 2]; // [RULE1]
				end
				if (q.ptr == REG_SEQ_CTRL) begin
					d.start = q.sh[START_BIT]; // [RULE12]
					d.restart = q.sh[START_BIT] & ~q.start; // [RULE3]
				end
				if (q.ptr == REG_SWITCH) begin
					d.sw = q.sh[NCH-1:0]; // [RULE5]
				end
				d.ptr = q.ptr + 8'h01;
			end else if (q.cnt == ACK_CLK_CNT && q.st == ST_RDATA && pin.sda) begin
				d.st = ST_IDLE;
			end
		end else if (q.st != ST_IDLE && scl_fall) begin
			if (q.cnt == ACK_CNT) begin
				d.cnt = ACK_CLK_CNT;
				if (q.st == ST_RDATA) begin
					d.oe = 1'b0;
				end else if (q.st == ST_ADDR && q.sh[7:1] != dev_addr) begin
					d.st = ST_IDLE;
				end else begin
					d.oe = 1'b1;
				end
			end else if (q.cnt == ACK_CLK_CNT) begin
				d.cnt = 4'h0;
				d.oe = 1'b0;
				unique case (q.st)
					ST_ADDR: begin
						if (q.sh[0]) begin
							d.st = ST_RDATA;
							d.sh = rd_val;
							d.oe = ~rd_val[7];
							d.ptr = q.ptr + 8'h01;
						end else begin
							d.st = ST_REG;
						end
					end
					ST_REG: begin
						d.ptr = q.sh;
						d.st = ST_WDATA;
					end
					ST_RDATA: begin
						d.sh = rd_val;
						d.oe = ~rd_val[7];
						d.ptr = q.ptr + 8'h01;
					end
					ST_WDATA: begin
						d.st = ST_WDATA;
					end
					default: begin
						d.st = ST_IDLE;
					end
				endcase
			end else if (q.st == ST_RDATA && q.cnt != 4'h0) begin
				d.sh = {q.sh[6:0], 1'b0};
				d.oe = ~q.sh[6];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= TOP_RESET;
		end else begin
			q <= d;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = q.oe;

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		chan_cfg_t cfg;
		assign cfg = '{en: q.cyc[i][CYC_EN_BIT], cyc: q.cyc[i][CYC_LSB +: 3],
			on: q.timing[i][ON_LSB +: 4], off: q.timing[i][OFF_LSB +: 4],
			sw: q.sw[i]};
		blink_channel u_ch (
			.ref_clk (ref_clk),
			.reset_n (reset_n),
			.tick    (tick),
			.restart (q.restart),
			.blink   (cfg.en & group_ok), // [RULE1] [RULE2]
			.run     (q.start), // [RULE14]
			.cfg     (cfg),
			.led     (led_drive[i])
		);
	end

	a_write_at_ack: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		(q.st == ST_WDATA && q.cnt == ACK_CLK_CNT && scl_rise && !start_c
		&& !stop_c && q.ptr == REG_SEQ_CTRL) |=> (q.start == $past(q.sh[START_BIT])))
		else $error("control write missed its ack edge");
	a_no_early_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		(q.cnt != ACK_CLK_CNT || !scl_rise) |=> $stable(q.timing))
		else $error("timing changed outside an ack edge");
	a_start_restart: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE3]
		$rose(q.start) |-> q.restart ##1 (q.pre == 16'h0000))
		else $error("start did not realign channels");
	a_group_gate: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE1]
		(q.group != GROUP_BLINK) |=> (led_drive == $past(q.sw)))
		else $error("blink ran outside group select 01b");
	a_tick_reload: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE14]
		tick |=> (q.pre == 16'h0000))
		else $error("prescaler did not reload");
	a_idle_released: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		(start_c || stop_c) |=> !sda_oe ##1 (q.st != ST_IDLE || !sda_oe))
		else $error("sda held after start or stop");
	a_ack_drive: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		(q.st == ST_REG && q.cnt == ACK_CNT && scl_fall && !start_c && !stop_c)
		|=> sda_oe)
		else $error("register byte not acknowledged");

	// bus framing, acknowledge and register pointer checks
	a_start_frame: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		start_c |=> (q.st == ST_ADDR && q.cnt == 4'h0))
		else $error("start did not open a frame");
	a_stop_frame: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		stop_c |=> (q.st == ST_IDLE))
		else $error("stop did not close the frame");
	a_addr_match: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		(q.st == ST_ADDR && q.cnt == ACK_CNT && scl_fall && q.sh[7:1] == dev_addr)
		|=> sda_oe)
		else $error("own address not acknowledged");
	a_addr_other: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		(q.st == ST_ADDR && q.cnt == ACK_CNT && scl_fall && q.sh[7:1] != dev_addr)
		|=> (q.st == ST_IDLE && !sda_oe))
		else $error("foreign address not ignored");
	a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		(q.st == ST_IDLE) |-> !sda_oe)
		else $error("sda driven while idle");
	a_ack_release: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		((q.st == ST_REG || q.st == ST_WDATA) && q.cnt == ACK_CLK_CNT && scl_fall)
		|=> !sda_oe)
		else $error("ack held past its clock");
	a_rd_ack_free: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		(q.st == ST_RDATA && q.cnt == ACK_CNT && scl_fall) |=> (!sda_oe && q.cnt == ACK_CLK_CNT))
		else $error("sda not freed for master ack");
	a_rd_hold: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		(q.st == ST_RDATA && scl_rise && q.cnt < ACK_CNT) |=> ($stable(q.sh) && $stable(sda_oe)))
		else $error("read data moved while scl high");
	a_nack_ends: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		(q.st == ST_RDATA && q.cnt == ACK_CLK_CNT && scl_rise && pin.sda) |=> (q.st == ST_IDLE))
		else $error("master nack did not end the read");
	a_ptr_load: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		(q.st == ST_REG && q.cnt == ACK_CLK_CNT && scl_fall)
		|=> (q.st == ST_WDATA && q.ptr == $past(q.sh)))
		else $error("register pointer not loaded");
	a_ptr_step: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		(q.st == ST_WDATA && q.cnt == ACK_CLK_CNT && scl_rise) |=> (q.ptr == $past(q.ptr) + 8'h01))
		else $error("pointer did not advance after write");
	a_cnt_bound: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE13]
		q.cnt <= ACK_CLK_CNT)
		else $error("bit counter out of range");

	a_timing_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE6]
		(q.st == ST_WDATA && q.cnt == ACK_CLK_CNT && scl_rise && q.ptr == ch_reg(0, 1'b0))
		|=> (q.timing[0] == $past(q.sh)))
		else $error("red timing write lost");
	a_switch_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE5]
		(q.st == ST_WDATA && q.cnt == ACK_CLK_CNT && scl_rise && q.ptr == REG_SWITCH)
		|=> (q.sw == $past(q.sh[NCH-1:0])))
		else $error("switch write lost");
	a_group_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE1]
		(q.st == ST_WDATA && q.cnt == ACK_CLK_CNT && scl_rise && q.ptr == REG_GROUP_CFG)
		|=> (q.group == $past(q.sh[GROUP_LSB +: 2])))
		else $error("group select write lost");
	a_start_hold: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE12]
		(q.st != ST_WDATA || q.cnt != ACK_CLK_CNT || !scl_rise) |=> $stable(q.start))
		else $error("start bit changed outside a write");
	a_restart_once: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE3]
		q.restart |=> !q.restart)
		else $error("restart longer than one cycle");
	a_restart_cause: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE3]
		q.restart |-> (q.start && !$past(q.start)))
		else $error("restart without a start rise");
	a_pre_bound: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE14]
		q.pre <= PRE_LAST)
		else $error("prescaler ran past its end");

	c_start_write: cover property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(q.start));
	c_read_byte: cover property (@(posedge ref_clk) disable iff (!reset_n)
		q.st == ST_RDATA && scl_fall && q.cnt == ACK_CLK_CNT);
	c_group_on: cover property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(group_ok));
endmodule
`default_nettype wire

// ---- design/pin_sync.sv ----
// two-flop synchroniser for the serial bus pins and the address strap
// assumes: pins are asynchronous to ref_clk and idle high
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input  wire logic                ref_clk,
	input  wire logic                reset_n,
	input  wire blink_pkg::bus_pins_t pins_in,
	output var  blink_pkg::bus_pins_t pins_out
);
	import blink_pkg::*;

	sync_state_t q;
	sync_state_t d;

	always_comb begin
		d.meta = pins_in;
		d.stable = q.meta;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= SYNC_IDLE;
		end else begin
			q <= d;
		end
	end

	assign pins_out = q.stable;
endmodule
`default_nettype wire

// ---- shared/blink_pkg.sv ----
// package: constants and types for the led blink sequencer
// assumes: 40 MHz ref_clk, registers reached over the two-wire serial port
package blink_pkg;
	localparam int CLK_PERIOD_NS = 25;
	// one tick is 1/200 ms, so a step of 1/200 cycle lasts cycle_ms ticks
	localparam int TICK_NS = 5000;
	localparam int TICK_CLKS = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NCH = 3;
	localparam logic [7:0] STEPS = 8'hC8;
	localparam logic [6:0] DEV_ADDR_BASE = 7'h54;
	localparam logic [7:0] REG_CH_BASE = 8'h01;
	localparam logic [7:0] REG_CH_STRIDE = 8'h02;
	localparam logic [7:0] REG_GROUP_CFG = 8'h0B;
	localparam logic [7:0] REG_SEQ_CTRL = 8'h11;
	localparam logic [7:0] REG_SWITCH = 8'h12;
	localparam int CYC_EN_BIT = 3;
	localparam int CYC_LSB = 0;
	localparam int ON_LSB = 4;
	localparam int OFF_LSB = 0;
	localparam int START_BIT = 3;
	localparam int GROUP_LSB = 0;
	localparam logic [1:0] GROUP_BLINK = 2'h1;
	localparam logic [3:0] ACK_CNT = 4'h8;
	localparam logic [3:0] ACK_CLK_CNT = 4'h9;
	// on/off codes in half-percent steps: 0,1,2.5,5,7.5,10,15,20,30..90,100 %
	localparam logic [15:0][7:0] PCT_HALF = {8'hC8, 8'hB4, 8'hA0, 8'h8C,
		8'h78, 8'h64, 8'h50, 8'h3C, 8'h28, 8'h1E, 8'h14, 8'h0F,
		8'h0A, 8'h05, 8'h02, 8'h00};
	// cycle time in ms: 100, 250, 500, 1000, 2000, 3000, 4000, 5000
	localparam logic [7:0][12:0] CYCLE_MS = {13'h1388, 13'h0FA0, 13'h0BB8,
		13'h07D0, 13'h03E8, 13'h01F4, 13'h00FA, 13'h0064};

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_REG   = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100
	} i2c_state_t;

	typedef struct packed {
		logic       addr_sel;
		logic       sda;
		logic       scl;
	} bus_pins_t;

	typedef struct packed {
		bus_pins_t  meta;
		bus_pins_t  stable;
	} sync_state_t;

	typedef struct packed {
		logic       en;
		logic [2:0] cyc;
		logic [3:0] on;
		logic [3:0] off;
		logic       sw;
	} chan_cfg_t;

	typedef struct packed {
		logic [12:0] step;
		logic [7:0]  phase;
		logic        led;
	} chan_state_t;

	typedef struct packed {
		i2c_state_t          st;
		logic [3:0]          cnt;
		logic [7:0]          sh;
		logic [7:0]          ptr;
		logic                oe;
		logic                scl_prev;
		logic                sda_prev;
		logic [NCH-1:0][7:0] timing;
		logic [NCH-1:0][3:0] cyc;
		logic [1:0]          group;
		logic                start;
		logic [NCH-1:0]      sw;
		logic                restart;
		logic [15:0]         pre;
	} top_state_t;

	// edge detectors start at the idle bus level so no false edge follows reset
	localparam top_state_t TOP_RESET = '{st: ST_IDLE, scl_prev: 1'b1, sda_prev: 1'b1,
		default: '0};
	localparam chan_state_t CHAN_RESET = '0;
	localparam sync_state_t SYNC_IDLE = '1;

	function automatic logic [7:0] ch_reg(input int i, input logic cyc_reg);
		ch_reg = REG_CH_BASE + REG_CH_STRIDE * 8'(i) + {7'h00, cyc_reg};
	endfunction
endpackage
